// ===== design/sbctm_regs.sv
`timescale 1ns/1ps

// What this block does
// - can fast-mode bit 4: 0 keeps slew control, 1 drops it.
// - on-time bits 6:4 code 000 stops low; 001..101 select on-times.
// - on-time 110 stops with output high; 111 reserved, not running.
// - period bits 3:0 select 10 ms up to 1000 s in order.
// - timer runs once assigned to a user and a running on-time set.
// - cyclic sense plus switch cleared in restart clears timer settings.
// - cyclic sense and cyclic wake share one timer concurrently.
// - timer configuration takes effect as chip select rises.
// - timer register clears on power-on, soft reset and restart entry.
// - hysteresis bit 7 set forces top release threshold.
// - wait bit 5 set extends thermal wait x64 from the 17th event on.
// - reset delay bit 4: 0 long delay, 1 short delay.
// - level-0 lock bit 3 blocks charge pump and gpio writes.
// - other lockable bits are governed by the level-1 lock.
// - locked bits keep their value through soft reset.
// - level-1 lock makes soft reset keep hysteresis, wait and delay bits.
// - reserved bits ignore writes and read zero.
// - timer wake enable bit makes timer a cyclic wake source.
// - gpio code 011 assigns high side to timer for cyclic sense.
module sbctm_regs #(
  parameter int TICK_CYCLES = sbctm_pkg::TICK_CYCLES
) (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       chip_select_n,
  input  wire logic       wr_valid,
  input  wire logic [6:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       rd_en,
  input  wire logic [6:0] rd_addr,
  input  wire logic       soft_reset,
  input  wire logic       restart_entry,
  input  wire logic       restart_active,
  input  wire logic       hs_switch_cleared,
  input  wire logic       ovt_event,
  input  wire logic       ovt_calm,
  output logic [7:0]      rd_data_q,
  output logic            can_fast_mode_q,
  output logic            can_slew_control_q,
  output logic            reset_release_hysteresis_sel_q,
  output logic            overtemp_wait_extension_q,
  output logic            ovt_wait_x64_q,
  output logic            reset_delay_sel_q,
  output logic            charge_pump_enable_q,
  output logic [2:0]      gpio_config_q,
  output logic            timer_wake_enable_q,
  output logic            high_side_output,
  output logic            timer_wake_pulse_q,
  output logic            timer_running
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic       can_fast_mode_d, can_slew_control_d;
  logic [2:0] timer_on_q, timer_on_d;
  logic [3:0] timer_period_q, timer_period_d;
  logic       rst_hys_d, ovt_del_d, rst_del_d;
  logic       lock0_q, lock0_d, lock1_q, lock1_d;
  logic       wake_en_d, pump_en_d;
  logic [2:0] gpio_d;
  logic       pend_valid_q, pend_valid_d;
  logic [6:0] pend_addr_q, pend_addr_d;
  logic [7:0] pend_data_q, pend_data_d;
  logic       sel_prev_q;
  logic       tload_q, tload_d;
  logic [7:0] rd_data_d;
  logic [4:0] ovt_cnt_q, ovt_cnt_d;
  logic       x64_d, wake_pulse_d;
  logic       sel_rise, commit, assigned;
  logic       period_start;

  // ------------------------------------------------------------
  // write staging and commit
  // ------------------------------------------------------------
  always_comb begin
    can_fast_mode_d = can_fast_mode_q;
    timer_on_d      = timer_on_q;
    timer_period_d  = timer_period_q;
    rst_hys_d       = reset_release_hysteresis_sel_q;
    ovt_del_d       = overtemp_wait_extension_q;
    rst_del_d       = reset_delay_sel_q;
    lock0_d         = lock0_q;
    lock1_d         = lock1_q;
    wake_en_d       = timer_wake_enable_q;
    pump_en_d       = charge_pump_enable_q;
    gpio_d          = gpio_config_q;
    pend_valid_d    = pend_valid_q;
    pend_addr_d     = pend_addr_q;
    pend_data_d     = pend_data_q;
    tload_d         = 1'b0;
    sel_rise        = chip_select_n && !sel_prev_q;
    commit          = pend_valid_q && sel_rise;

    if (sel_rise) begin
      pend_valid_d = 1'b0;
    end
    if (wr_valid && !chip_select_n) begin
      pend_valid_d = 1'b1;
      pend_addr_d  = wr_addr;
      pend_data_d  = wr_data;
    end

    if (commit) begin
      unique case (pend_addr_q)
        sbctm_pkg::ADDR_BUS_CTRL3: begin
          can_fast_mode_d = pend_data_q[sbctm_pkg::BIT_CAN_FLASH];
        end
        sbctm_pkg::ADDR_TIMER: begin
          timer_on_d     =
            pend_data_q[sbctm_pkg::ON_MSB:sbctm_pkg::ON_LSB];
          timer_period_d =
            pend_data_q[sbctm_pkg::PER_MSB:sbctm_pkg::PER_LSB];
          tload_d        = 1'b1;
        end
        sbctm_pkg::ADDR_HW_CTRL1: begin
          if (!lock1_q) begin
            rst_hys_d  = pend_data_q[sbctm_pkg::BIT_RST_HYS];
            ovt_del_d  = pend_data_q[sbctm_pkg::BIT_OVT_DEL];
            rst_del_d  = pend_data_q[sbctm_pkg::BIT_RST_DEL];
          end
          lock0_d = pend_data_q[sbctm_pkg::BIT_LOCK0];
        end
        sbctm_pkg::ADDR_HW_CTRL2: begin
          // lock1 sticks until power-up
          if (!lock1_q) begin
            lock1_d = pend_data_q[sbctm_pkg::BIT_LOCK1];
          end
        end
        sbctm_pkg::ADDR_WAKE_CTRL: begin
          wake_en_d = pend_data_q[sbctm_pkg::BIT_TIMER_WAKE];
        end
        sbctm_pkg::ADDR_GPIO_CTRL: begin
          if (!lock0_q) begin
            gpio_d = pend_data_q[sbctm_pkg::GPIO_MSB:0];
          end
        end
        sbctm_pkg::ADDR_CP_CTRL: begin
          if (!lock0_q) begin
            pump_en_d = pend_data_q[sbctm_pkg::BIT_PUMP_EN];
          end
        end
        default: begin
        end
      endcase
    end

    if (restart_active && hs_switch_cleared &&
        gpio_config_q == sbctm_pkg::GPIO_SENSE) begin
      timer_on_d     = sbctm_pkg::ON_RESET;
      timer_period_d = sbctm_pkg::PER_RESET;
      tload_d        = 1'b1;
    end

    if (soft_reset) begin
      pend_valid_d    = 1'b0;
      can_fast_mode_d = 1'b0;
      wake_en_d       = 1'b0;
      if (!lock1_q) begin
        rst_hys_d  = 1'b0;
        ovt_del_d  = 1'b0;
        rst_del_d  = 1'b0;
      end
      if (!lock0_q) begin
        gpio_d    = sbctm_pkg::GPIO_RESET;
        pump_en_d = 1'b0;
      end
    end

    if (soft_reset || restart_entry) begin
      timer_on_d     = sbctm_pkg::ON_RESET;
      timer_period_d = sbctm_pkg::PER_RESET;
      tload_d        = 1'b1;
    end
    can_slew_control_d = !can_fast_mode_d;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      can_fast_mode_q                <= 1'b0;
      can_slew_control_q             <= 1'b1;
      timer_on_q                     <= sbctm_pkg::ON_RESET;
      timer_period_q                 <= sbctm_pkg::PER_RESET;
      reset_release_hysteresis_sel_q <= 1'b0;
      overtemp_wait_extension_q      <= 1'b0;
      reset_delay_sel_q              <= 1'b0;
      lock0_q                        <= 1'b0;
      lock1_q                        <= 1'b0;
      timer_wake_enable_q            <= 1'b0;
      charge_pump_enable_q           <= 1'b0;
      gpio_config_q                  <= sbctm_pkg::GPIO_RESET;
      pend_valid_q                   <= 1'b0;
      pend_addr_q                    <= '0;
      pend_data_q                    <= '0;
      sel_prev_q                     <= 1'b1;
      tload_q                        <= 1'b0;
    end else begin
      can_fast_mode_q                <= can_fast_mode_d;
      can_slew_control_q             <= can_slew_control_d;
      timer_on_q                     <= timer_on_d;
      timer_period_q                 <= timer_period_d;
      reset_release_hysteresis_sel_q <= rst_hys_d;
      overtemp_wait_extension_q      <= ovt_del_d;
      reset_delay_sel_q              <= rst_del_d;
      lock0_q                        <= lock0_d;
      lock1_q                        <= lock1_d;
      timer_wake_enable_q            <= wake_en_d;
      charge_pump_enable_q           <= pump_en_d;
      gpio_config_q                  <= gpio_d;
      pend_valid_q                   <= pend_valid_d;
      pend_addr_q                    <= pend_addr_d;
      pend_data_q                    <= pend_data_d;
      sel_prev_q                     <= chip_select_n;
      tload_q                        <= tload_d;
    end
  end

  // ------------------------------------------------------------
  // readback and thermal wait
  // ------------------------------------------------------------
  always_comb begin
    rd_data_d = rd_data_q;
    if (rd_en) begin
      rd_data_d = 8'h00;
      unique case (rd_addr)
        sbctm_pkg::ADDR_BUS_CTRL3:
          rd_data_d[sbctm_pkg::BIT_CAN_FLASH] = can_fast_mode_q;
        sbctm_pkg::ADDR_TIMER: begin
          rd_data_d[sbctm_pkg::ON_MSB:sbctm_pkg::ON_LSB] = timer_on_q;
          rd_data_d[sbctm_pkg::PER_MSB:sbctm_pkg::PER_LSB] =
            timer_period_q;
        end
        sbctm_pkg::ADDR_HW_CTRL1: begin
          rd_data_d[sbctm_pkg::BIT_RST_HYS] =
            reset_release_hysteresis_sel_q;
          rd_data_d[sbctm_pkg::BIT_OVT_DEL]  = overtemp_wait_extension_q;
          rd_data_d[sbctm_pkg::BIT_RST_DEL]  = reset_delay_sel_q;
          rd_data_d[sbctm_pkg::BIT_LOCK0]    = lock0_q;
        end
        sbctm_pkg::ADDR_HW_CTRL2:
          rd_data_d[sbctm_pkg::BIT_LOCK1] = lock1_q;
        sbctm_pkg::ADDR_WAKE_CTRL:
          rd_data_d[sbctm_pkg::BIT_TIMER_WAKE] = timer_wake_enable_q;
        sbctm_pkg::ADDR_GPIO_CTRL:
          rd_data_d[sbctm_pkg::GPIO_MSB:0] = gpio_config_q;
        sbctm_pkg::ADDR_CP_CTRL:
          rd_data_d[sbctm_pkg::BIT_PUMP_EN] = charge_pump_enable_q;
        default: begin
        end
      endcase
    end

    ovt_cnt_d = ovt_cnt_q;
    if (ovt_event) begin
      if (ovt_cnt_q <= sbctm_pkg::OVT_CONSEC) begin
        ovt_cnt_d = ovt_cnt_q + 5'h01;
      end
    end else if (ovt_calm) begin
      ovt_cnt_d = 5'h00;
    end
    x64_d = overtemp_wait_extension_q &&
            ovt_cnt_d > sbctm_pkg::OVT_CONSEC;

    wake_pulse_d = period_start && timer_wake_enable_q;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_q          <= 8'h00;
      ovt_cnt_q          <= 5'h00;
      ovt_wait_x64_q     <= 1'b0;
      timer_wake_pulse_q <= 1'b0;
    end else begin
      rd_data_q          <= rd_data_d;
      ovt_cnt_q          <= ovt_cnt_d;
      ovt_wait_x64_q     <= x64_d;
      timer_wake_pulse_q <= wake_pulse_d;
    end
  end

  // ------------------------------------------------------------
  // shared cyclic timer
  // ------------------------------------------------------------
  // timer users
  assign assigned = timer_wake_enable_q ||
                    gpio_config_q == sbctm_pkg::GPIO_SENSE;

  sbctm_cyc_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .mclk           (mclk),
    .rst_b          (rst_b),
    .on_code        (timer_on_q),
    .per_code       (timer_period_q),
    .assigned       (assigned),
    .cfg_load       (tload_q),
    .hs_q           (high_side_output),
    .period_start_q (period_start),
    .running_q      (timer_running)
  );

endmodule // sbctm_regs

// ===== shared/sbctm_pkg.sv
package sbctm_pkg;

  // ------------------------------------------------------------
  // register addresses (7-bit frame address)
  // ------------------------------------------------------------
  localparam logic [6:0] ADDR_WAKE_CTRL = 7'h06;
  localparam logic [6:0] ADDR_BUS_CTRL3 = 7'h0b;
  localparam logic [6:0] ADDR_TIMER     = 7'h0c;
  localparam logic [6:0] ADDR_HW_CTRL1  = 7'h0e;
  localparam logic [6:0] ADDR_HW_CTRL2  = 7'h0f;
  localparam logic [6:0] ADDR_CP_CTRL   = 7'h10;
  localparam logic [6:0] ADDR_GPIO_CTRL = 7'h17;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BIT_CAN_FLASH  = 4;
  localparam int BIT_TIMER_WAKE = 6;
  localparam int BIT_RST_HYS    = 7;
  localparam int BIT_OVT_DEL    = 5;
  localparam int BIT_RST_DEL    = 4;
  localparam int BIT_LOCK0      = 3;
  localparam int BIT_LOCK1      = 0;
  localparam int BIT_PUMP_EN    = 0;
  localparam int ON_MSB         = 6;
  localparam int ON_LSB         = 4;
  localparam int PER_MSB        = 3;
  localparam int PER_LSB        = 0;
  localparam int GPIO_MSB       = 2;

  // ------------------------------------------------------------
  // reset values and codes
  // ------------------------------------------------------------
  localparam logic [2:0] ON_RESET   = 3'h0;
  localparam logic [3:0] PER_RESET  = 4'h0;
  localparam logic [2:0] GPIO_RESET = 3'h0;
  localparam logic [2:0] ON_STOP_LO = 3'h0;
  localparam logic [2:0] ON_STOP_HI = 3'h6;
  localparam logic [2:0] ON_LAST    = 3'h5;
  localparam logic [2:0] GPIO_SENSE = 3'h3;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_NS       = 100000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_W        = 12;
  localparam int CNT_W         = 24;
  localparam logic [4:0] OVT_CONSEC = 5'h10;

  typedef enum logic [1:0] {
    SBCTM_IDLE = 2'b00,
    SBCTM_ON   = 2'b01,
    SBCTM_OFF  = 2'b10
  } sbctm_state_type;

  // on-time in 0.1 ms ticks
  function automatic logic [CNT_W-1:0] on_ticks(input logic [2:0] c);
    unique case (c)
      3'h1:    on_ticks = 24'h000001;
      3'h2:    on_ticks = 24'h000003;
      3'h3:    on_ticks = 24'h00000a;
      3'h4:    on_ticks = 24'h000064;
      3'h5:    on_ticks = 24'h0000c8;
      default: on_ticks = 24'h000000;
    endcase
  endfunction

  // period in 0.1 ms ticks
  function automatic logic [CNT_W-1:0] per_ticks(input logic [3:0] c);
    unique case (c)
      4'h0: per_ticks = 24'h000064;
      4'h1: per_ticks = 24'h0000c8;
      4'h2: per_ticks = 24'h0001f4;
      4'h3: per_ticks = 24'h0003e8;
      4'h4: per_ticks = 24'h0007d0;
      4'h5: per_ticks = 24'h001388;
      4'h6: per_ticks = 24'h002710;
      4'h7: per_ticks = 24'h004e20;
      4'h8: per_ticks = 24'h00c350;
      4'h9: per_ticks = 24'h0186a0;
      4'ha: per_ticks = 24'h030d40;
      4'hb: per_ticks = 24'h07a120;
      4'hc: per_ticks = 24'h0f4240;
      4'hd: per_ticks = 24'h1e8480;
      4'he: per_ticks = 24'h4c4b40;
      4'hf: per_ticks = 24'h989680;
    endcase
  endfunction

endpackage

// ===== design/sbctm_cyc_timer.sv
`timescale 1ns/1ps

module sbctm_cyc_timer #(
  parameter int TICK_CYCLES = sbctm_pkg::TICK_CYCLES
) (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic [2:0] on_code,
  input  wire logic [3:0] per_code,
  input  wire logic       assigned,
  input  wire logic       cfg_load,
  output logic            hs_q,
  output logic            period_start_q,
  output logic            running_q
);

  localparam logic [sbctm_pkg::TICK_W-1:0] TICK_LAST =
    sbctm_pkg::TICK_W'(TICK_CYCLES - 1);

  sbctm_pkg::sbctm_state_type        st_q, st_d;
  logic [sbctm_pkg::TICK_W-1:0]      presc_q, presc_d;
  logic [sbctm_pkg::CNT_W-1:0]       cnt_q, cnt_d, cnt_inc;
  logic                              hs_d, pstart_d, run;

  always_comb begin
    st_d     = st_q;
    presc_d  = presc_q;
    cnt_d    = cnt_q;
    pstart_d = 1'b0;
    cnt_inc  = cnt_q + 24'h000001;
    run = assigned && on_code != sbctm_pkg::ON_STOP_LO &&
          on_code <= sbctm_pkg::ON_LAST;
    if (!run) begin
      st_d    = sbctm_pkg::SBCTM_IDLE;
      presc_d = '0;
      cnt_d   = '0;
    end else if (cfg_load || st_q == sbctm_pkg::SBCTM_IDLE) begin
      st_d     = sbctm_pkg::SBCTM_ON;
      presc_d  = '0;
      cnt_d    = '0;
      pstart_d = 1'b1;
    end else if (presc_q == TICK_LAST) begin
      presc_d = '0;
      cnt_d   = cnt_inc;
      if (cnt_inc == sbctm_pkg::on_ticks(on_code)) begin
        st_d = sbctm_pkg::SBCTM_OFF;
      end
      if (cnt_inc == sbctm_pkg::per_ticks(per_code)) begin
        st_d     = sbctm_pkg::SBCTM_ON;
        cnt_d    = '0;
        pstart_d = 1'b1;
      end
    end else begin
      presc_d = presc_q + 12'h001;
    end
    if (!run) begin
      hs_d = (on_code == sbctm_pkg::ON_STOP_HI);
    end else begin
      hs_d = (st_d == sbctm_pkg::SBCTM_ON);
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q           <= sbctm_pkg::SBCTM_IDLE;
      presc_q        <= '0;
      cnt_q          <= '0;
      hs_q           <= 1'b0;
      period_start_q <= 1'b0;
      running_q      <= 1'b0;
    end else begin
      st_q           <= st_d;
      presc_q        <= presc_d;
      cnt_q          <= cnt_d;
      hs_q           <= hs_d;
      period_start_q <= pstart_d;
      running_q      <= run;
    end
  end

endmodule // sbctm_cyc_timer

// ===== dv/sbctm_host_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// host frame driver
// ------------------------------------------------------------
module sbctm_host_model (
  input  wire logic       mclk,
  input  wire logic [7:0] rd_data_q,
  output logic            chip_select_n,
  output logic            wr_valid,
  output logic [6:0]      wr_addr,
  output logic [7:0]      wr_data,
  output logic            rd_en,
  output logic [6:0]      rd_addr
);
  initial begin
    chip_select_n = 1'b1;
    wr_valid      = 1'b0;
    wr_addr       = 7'h00;
    wr_data       = 8'h00;
    rd_en         = 1'b0;
    rd_addr       = 7'h00;
  end

  // one write per frame, lines scrambled once released
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge mclk);
    chip_select_n = 1'b0;
    wr_valid      = 1'b1;
    wr_addr       = a;
    wr_data       = d;
    @(negedge mclk);
    chip_select_n = 1'b1;
    wr_valid      = 1'b0;
    wr_addr       = ~a;
    wr_data       = ~d;
    repeat (2) @(negedge mclk);
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge mclk);
    rd_en   = 1'b1;
    rd_addr = a;
    @(negedge mclk);
    rd_en   = 1'b0;
    rd_addr = ~a;
    d       = rd_data_q;
  endtask
endmodule // sbctm_host_model

// ===== dv/sbctm_regs_assertions.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// port checker
// ------------------------------------------------------------
module sbctm_regs_chk #(
  parameter int TICK_CYCLES = sbctm_pkg::TICK_CYCLES
) (
  input wire logic       mclk,
  input wire logic       rst_b,
  input wire logic       chip_select_n,
  input wire logic       soft_reset,
  input wire logic       restart_entry,
  input wire logic       can_fast_mode_q,
  input wire logic       can_slew_control_q,
  input wire logic       overtemp_wait_extension_q,
  input wire logic       ovt_wait_x64_q,
  input wire logic       reset_delay_sel_q,
  input wire logic [2:0] gpio_config_q,
  input wire logic       timer_wake_enable_q,
  input wire logic       high_side_output,
  input wire logic       timer_wake_pulse_q,
  input wire logic       timer_running
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence commit_s;
    $past(chip_select_n) && !$past(chip_select_n, 2);
  endsequence

  sequence soft_s;
    $past(soft_reset);
  endsequence

  AST_SLEW_INV: assert property (
    can_slew_control_q == !can_fast_mode_q)
    else $error("slew control not inverse of fast mode");
  AST_RUN_HS: assert property (
    $rose(timer_running) |-> ##[0:2] high_side_output)
    else $error("running timer did not raise output");
  AST_SOFT_CLR: assert property (
    soft_reset |-> ##[1:3] (!timer_running && !can_fast_mode_q
                            && !timer_wake_enable_q))
    else $error("soft reset left settings");
  AST_RESTART_CLR: assert property (
    restart_entry |-> ##[1:3] !timer_running)
    else $error("restart entry left timer running");
  AST_WAKE_SRC: assert property (
    timer_wake_pulse_q |-> $past(timer_wake_enable_q))
    else $error("wake pulse without wake enable");
  AST_PULSE_ONE: assert property (
    timer_wake_pulse_q |=> !timer_wake_pulse_q)
    else $error("wake pulse longer than one cycle");
  AST_X64_CAUSE: assert property (
    $rose(ovt_wait_x64_q) |-> $past(overtemp_wait_extension_q))
    else $error("wait extension without select bit");
  AST_GPIO_HOLD: assert property (
    $changed(gpio_config_q) |-> (commit_s or soft_s))
    else $error("gpio changed outside commit");
  AST_DELAY_HOLD: assert property (
    $changed(reset_delay_sel_q) |-> (commit_s or soft_s))
    else $error("reset delay changed outside commit");
endmodule // sbctm_regs_chk

bind sbctm_regs sbctm_regs_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .mclk(mclk), .rst_b(rst_b), .chip_select_n(chip_select_n),
  .soft_reset(soft_reset), .restart_entry(restart_entry),
  .can_fast_mode_q(can_fast_mode_q),
  .can_slew_control_q(can_slew_control_q),
  .overtemp_wait_extension_q(overtemp_wait_extension_q),
  .ovt_wait_x64_q(ovt_wait_x64_q),
  .reset_delay_sel_q(reset_delay_sel_q),
  .gpio_config_q(gpio_config_q),
  .timer_wake_enable_q(timer_wake_enable_q),
  .high_side_output(high_side_output),
  .timer_wake_pulse_q(timer_wake_pulse_q),
  .timer_running(timer_running));

// ===== dv/testbench.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// register bank bench
// ------------------------------------------------------------
module testbench;
  localparam int         TC   = 4;
  localparam logic [6:0] A_TM = sbctm_pkg::ADDR_TIMER;
  localparam logic [6:0] A_HW = sbctm_pkg::ADDR_HW_CTRL1;
  localparam logic [6:0] A_BC = sbctm_pkg::ADDR_BUS_CTRL3;
  localparam logic [6:0] A_WK = sbctm_pkg::ADDR_WAKE_CTRL;
  localparam logic [6:0] A_GP = sbctm_pkg::ADDR_GPIO_CTRL;
  localparam logic [6:0] A_CP = sbctm_pkg::ADDR_CP_CTRL;
  logic       mclk, rst_b, chip_select_n, wr_valid, rd_en;
  logic [6:0] wr_addr, rd_addr;
  logic [7:0] wr_data, rd_data_q;
  logic       soft_reset, restart_entry, restart_active;
  logic       hs_switch_cleared, ovt_event, ovt_calm;
  logic       can_fast_mode_q, can_slew_control_q, ovt_wait_x64_q;
  logic       reset_release_hysteresis_sel_q, overtemp_wait_extension_q;
  logic       reset_delay_sel_q, charge_pump_enable_q, timer_running;
  logic       timer_wake_enable_q, high_side_output, timer_wake_pulse_q;
  logic [2:0] gpio_config_q;
  int         error_cnt, n_checks, hi, pl, k;
  int         ont [5] = '{1, 3, 10, 100, 200};
  int         per [3] = '{100, 200, 500};

  sbctm_host_model u_host (.mclk, .rd_data_q, .chip_select_n, .wr_valid,
    .wr_addr, .wr_data, .rd_en, .rd_addr);

  sbctm_regs #(.TICK_CYCLES(TC)) dut (.mclk, .rst_b, .chip_select_n,
    .wr_valid, .wr_addr, .wr_data, .rd_en, .rd_addr, .soft_reset,
    .restart_entry, .restart_active, .hs_switch_cleared, .ovt_event,
    .ovt_calm, .rd_data_q, .can_fast_mode_q, .can_slew_control_q,
    .reset_release_hysteresis_sel_q, .overtemp_wait_extension_q,
    .ovt_wait_x64_q, .reset_delay_sel_q, .charge_pump_enable_q,
    .gpio_config_q, .timer_wake_enable_q, .high_side_output,
    .timer_wake_pulse_q, .timer_running);

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  task automatic bchk(input logic g, input logic e);
    chk({23'h0, g}, {23'h0, e});
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.wr(a, d);
  endtask

  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.rd(a, d);
    chk({16'h0, d}, {16'h0, e});
  endtask

  task automatic pulse(ref logic s);
    @(negedge mclk);
    s = 1'b1;
    @(negedge mclk);
    s = 1'b0;
    repeat (2) @(negedge mclk);
  endtask

  // high cycles and wake pulses over a window
  task automatic meas(input int n);
    hi = 0;
    pl = 0;
    repeat (n) begin
      @(negedge mclk);
      if (high_side_output === 1'b1) hi++;
      if (timer_wake_pulse_q === 1'b1) pl++;
    end
  endtask

  task automatic wpul;
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while (timer_wake_pulse_q !== 1'b1 && k < 9000);
  endtask

  initial begin
    #2000000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    rst_b = 1'b0;
    soft_reset = 1'b0;
    restart_entry = 1'b0;
    restart_active = 1'b0;
    hs_switch_cleared = 1'b0;
    ovt_event = 1'b0;
    ovt_calm = 1'b0;
    repeat (20) @(negedge mclk);
    rst_b = 1'b1;
    bchk(can_slew_control_q, 1'b1);
    rchk(A_TM, 8'h00);
    wr(7'h7f, 8'hff);
    rchk(7'h7f, 8'h00);
    wr(A_BC, 8'hff);
    rchk(A_BC, 8'h10);
    bchk(can_slew_control_q, 1'b0);
    wr(A_BC, 8'h00);
    bchk(can_fast_mode_q, 1'b0);
    $display("test reset and can done");
    wr(A_TM, 8'hff);
    rchk(A_TM, 8'h7f);
    bchk(high_side_output, 1'b0);
    wr(A_TM, 8'h60);
    @(negedge mclk);
    bchk(high_side_output, 1'b1);
    wr(A_TM, 8'h00);
    @(negedge mclk);
    bchk(high_side_output, 1'b0);
    wr(A_TM, 8'h10);
    @(negedge mclk);
    bchk(timer_running, 1'b0);
    $display("test codes done");
    wr(A_GP, 8'h03);
    wr(A_WK, 8'h40);
    for (int c = 1; c < 6; c++) begin
      wr(A_TM, {1'b0, 3'(c), 4'h2});
      meas(2000);
      chk(24'(hi), 24'(ont[c-1] * TC));
      chk(24'(pl), 24'h1);
    end
    for (int p = 0; p < 3; p++) begin
      wr(A_TM, {4'h1, 4'(p)});
      wpul();
      wpul();
      chk(24'(k), 24'(per[p] * TC));
    end
    wr(A_TM, 8'h1f);
    repeat (20) @(negedge mclk);
    wr(A_TM, 8'h12);
    @(negedge mclk);
    bchk(high_side_output, 1'b1);
    bchk(timer_running, 1'b1);
    $display("test timer done");
    pulse(hs_switch_cleared);
    rchk(A_TM, 8'h12);
    restart_active = 1'b1;
    pulse(hs_switch_cleared);
    restart_active = 1'b0;
    rchk(A_TM, 8'h00);
    wr(A_TM, 8'h12);
    pulse(restart_entry);
    rchk(A_TM, 8'h00);
    wr(A_TM, 8'h12);
    wr(A_BC, 8'h10);
    pulse(soft_reset);
    rchk(A_TM, 8'h00);
    rchk(A_BC, 8'h00);
    rchk(A_WK, 8'h00);
    $display("test resets done");
    wr(A_GP, 8'h03);
    wr(A_HW, 8'hff);
    rchk(A_HW, 8'hb8);
    bchk(reset_release_hysteresis_sel_q, 1'b1);
    bchk(reset_delay_sel_q, 1'b1);
    bchk(overtemp_wait_extension_q, 1'b1);
    repeat (16) pulse(ovt_event);
    bchk(ovt_wait_x64_q, 1'b0);
    pulse(ovt_event);
    bchk(ovt_wait_x64_q, 1'b1);
    pulse(ovt_calm);
    bchk(ovt_wait_x64_q, 1'b0);
    wr(A_GP, 8'h05);
    rchk(A_GP, 8'h03);
    chk(24'(gpio_config_q), 24'h000003);
    wr(A_CP, 8'h01);
    rchk(A_CP, 8'h00);
    pulse(soft_reset);
    rchk(A_GP, 8'h03);
    rchk(A_HW, 8'h08);
    wr(A_HW, 8'h00);
    wr(A_GP, 8'h05);
    rchk(A_GP, 8'h05);
    wr(A_CP, 8'h01);
    bchk(charge_pump_enable_q, 1'b1);
    wr(A_HW, 8'h90);
    wr(sbctm_pkg::ADDR_HW_CTRL2, 8'h01);
    wr(A_HW, 8'h20);
    rchk(A_HW, 8'h90);
    pulse(soft_reset);
    rchk(A_HW, 8'h90);
    rchk(A_GP, 8'h00);
    $display("test locks done");
    print_verdict();
  end
endmodule // testbench
